//--- sync_slave_pkg.sv
// package: register map, field positions and reset values of the synchronous slave serial port
package sync_slave_pkg;
  // register byte offsets on the register bus
  localparam logic [7:0] OFF_TRANSMIT_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_RECEIVE_STATUS_CONTROL  = 8'h04;
  localparam logic [7:0] OFF_BAUD_CONTROL            = 8'h08;
  localparam logic [7:0] OFF_RECEIVE_DATA            = 8'h0C;
  localparam logic [7:0] OFF_TRANSMIT_BUFFER         = 8'h10;
  localparam logic [7:0] OFF_PERIPHERAL_IRQ_FLAGS    = 8'h14;
  localparam logic [7:0] OFF_PERIPHERAL_IRQ_ENABLES  = 8'h18;
  localparam logic [7:0] OFF_INTERRUPT_CONTROL       = 8'h1C;
  localparam logic [7:0] OFF_PIN_RELOCATION          = 8'h20;
  localparam logic [7:0] OFF_SLEEP_CONTROL           = 8'h24;

  // transmit_status_control fields
  localparam int TXS_CLOCK_SOURCE_MASTER = 7;
  localparam int TXS_NINE_BIT            = 6;
  localparam int TXS_TRANSMIT_ENABLE     = 5;
  localparam int TXS_SYNC_SELECT         = 4;
  localparam int TXS_SHIFTER_EMPTY       = 1;
  localparam int TXS_TRANSMIT_NINTH_BIT  = 0;
  // receive_status_control fields
  localparam int RXS_PORT_ENABLE               = 7;
  localparam int RXS_NINE_BIT                  = 6;
  localparam int RXS_SINGLE_RECEIVE_ENABLE     = 5;
  localparam int RXS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RXS_OVERRUN                   = 1;
  localparam int RXS_RECEIVE_NINTH_BIT         = 0;
  // baud_control fields
  localparam int BDC_RECEIVE_IDLE  = 6;
  localparam int BDC_CLOCK_INVERT  = 4;
  // peripheral flag and enable positions
  localparam int PIR_RECEIVE_READY = 5;
  localparam int PIR_TRANSMIT_SPACE = 4;
  // interrupt_control fields
  localparam int ICN_GLOBAL_IRQ_ENABLE     = 7;
  localparam int ICN_PERIPHERAL_IRQ_ENABLE = 6;

  // writable bit masks, unimplemented positions read zero
  localparam logic [7:0] TXS_WRITE_MASK = 8'hF1;
  localparam logic [7:0] RXS_WRITE_MASK = 8'hF0;
  localparam logic [7:0] BDC_WRITE_MASK = 8'h10;
  localparam logic [7:0] PIE_WRITE_MASK = 8'h30;
  localparam logic [7:0] ICN_WRITE_MASK = 8'hC0;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] PIN_RELOC_MASK = 8'h03;

  // interrupt vector taken when the global enable is set on wake
  localparam logic [11:0] IRQ_VECTOR = 12'h004;
  localparam int WORD_BITS = 8;

  typedef enum logic [1:0] {
    AXI_OKAY   = 2'b00,
    AXI_SLVERR = 2'b10
  } axi_resp_e;

  // pin relocation pair: clock and data use the alternate location when set
  typedef struct packed {
    logic data_alternate;
    logic clock_alternate;
  } pin_select_s;

  // word handed from the shift engine to the register side
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } serial_word_s;
endpackage

//--- slave_shift_engine.sv
// shift engine: samples the external serial clock and moves words through the shifters
`timescale 1ns/1ps
module slave_shift_engine
  import sync_slave_pkg::*;
#(
  parameter int BITS = WORD_BITS
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic         run_in,
  input  wire logic         receive_mode_in,
  input  wire logic         nine_bit_in,
  input  wire logic         clock_invert_in,
  input  wire logic         sck_in,
  input  wire logic         sdi_in,
  input  wire logic         load_in,
  input  wire serial_word_s load_word_in,
  output logic              sdo_out,
  output logic              shifter_empty_out,
  output logic              word_pulse_out,
  output serial_word_s      word_out,
  output logic              tx_taken_pulse_out
);
  // two-stage synchronisers for link clock and data pins
  logic [1:0] sck_sync;
  logic [1:0] sdi_sync;
  logic       sck_last;
  always_ff @(posedge clk_in) begin
    sck_sync <= {sck_sync[0], sck_in};
    sdi_sync <= {sdi_sync[0], sdi_in};
    sck_last <= sck_sync[1];
  end

  // shifter moves only on edges of the master's clock, never on its own rate
  wire sck_level = sck_sync[1] ^ clock_invert_in;
  wire sck_prev  = sck_last ^ clock_invert_in;
  wire edge_rise = run_in & sck_level & ~sck_prev; // [R02]
  wire edge_fall = run_in & ~sck_level & sck_prev; // [R02]
  wire [3:0] word_len = nine_bit_in ? 4'(BITS + 1) : 4'(BITS);

  logic [8:0] shifter;
  logic [3:0] count;
  logic       loaded;
  wire last_bit = (count == word_len - 4'h1);

  always_ff @(posedge clk_in) begin
    if (!resetn_in || !run_in) begin
      shifter            <= 9'h000;
      count              <= 4'h0;
      loaded             <= 1'b0;
      sdo_out            <= 1'b0;
      word_pulse_out     <= 1'b0;
      word_out           <= '0;
      tx_taken_pulse_out <= 1'b0;
    end else begin
      word_pulse_out     <= 1'b0;
      tx_taken_pulse_out <= 1'b0;
      if (receive_mode_in) begin
        // receive: sample data on the rising edge
        if (edge_rise) begin
          shifter <= {sdi_sync[1], shifter[8:1]}; // [R04]
          count   <= last_bit ? 4'h0 : count + 4'h1;
          if (last_bit) begin
            word_pulse_out <= 1'b1; // [R04]
            word_out <= nine_bit_in ? {sdi_sync[1], shifter[8:1]}
                                    : {1'b0, sdi_sync[1], shifter[8:2]};
          end
        end
      end else begin
        // transmit: buffer refills the empty shifter, bits change on falling edge
        if (!loaded && load_in) begin
          shifter            <= {load_word_in.ninth, load_word_in.data}; // [R08]
          loaded             <= 1'b1;
          count              <= 4'h0;
          sdo_out            <= load_word_in.data[0]; // [R07]
          tx_taken_pulse_out <= 1'b1; // [R08]
        end else if (loaded && edge_fall) begin
          if (last_bit) begin
            loaded <= 1'b0;
          end else begin
            shifter <= {1'b0, shifter[8:1]};
            sdo_out <= shifter[1]; // [R07]
            count   <= count + 4'h1;
          end
        end
      end
    end
  end

  assign shifter_empty_out = ~loaded;

  // a full receive word is reported within one cycle of its last edge
  rx_word_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (run_in && receive_mode_in && edge_rise && last_bit) |=> word_pulse_out) // [R04]
    else $error("receive word not reported");
  // no shifting while the port is stopped
  stop_idle_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !run_in |=> !word_pulse_out && !tx_taken_pulse_out) // [R01]
    else $error("shift engine active while stopped");
endmodule

//--- sync_slave_serial_sleep.sv
// top: synchronous slave serial port with register file, sleep wake and pin relocation
// Summary of operation
// [R01] in sleep, only synchronous slave mode shifts
// [R02] slave shifters clocked only by external clock
// [R03] software empties receive data before sleeping
// [R04] received full word sets receive-ready, wakes core
// [R05] wake resumes next instruction; vector 004h if enabled
// [R06] software fills transmit path before sleeping
// [R07] slave transmit drives data from pin clock
// [R08] shifter empties: buffer loads, transmit-space set
// [R09] writing transmit buffer clears transmit-space
// [R10] clock and data pins relocatable by register
// [R11] unimplemented register bits read zero
// [R12] sync, slave clock, port enable select slave
// [R13] overrun cleared by clearing receive or port enable
// [R14] ninth received bit shown in status field
// [R15] flags cross safely into the system domain
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module sync_slave_serial_sleep
  import sync_slave_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sleeping_in,
  input  wire logic        clock_pin_a_in,
  input  wire logic        clock_pin_b_in,
  input  wire logic        data_pin_a_in,
  input  wire logic        data_pin_b_in,
  output logic             data_pin_a_out,
  output logic             data_pin_a_oe_out,
  output logic             data_pin_b_out,
  output logic             data_pin_b_oe_out,
  output logic             wake_out,
  output logic             vector_call_out,
  output logic [11:0]      vector_addr_out,
  output logic             irq_out
);
  // control registers
  logic [7:0]   transmit_status_control;
  logic [7:0]   receive_status_control;
  logic [7:0]   baud_control;
  logic [7:0]   peripheral_irq_enables;
  logic [7:0]   interrupt_control;
  pin_select_s  pin_relocation_reg;
  serial_word_s receive_data_reg;
  serial_word_s transmit_buffer_reg;
  logic         transmit_buffer_full;
  logic         receive_ready_flag;
  logic         transmit_space_flag;
  logic         overrun;
  logic         sleep_seen;

  // mode decode from the configuration bits
  wire port_enable  = receive_status_control[RXS_PORT_ENABLE];
  wire sync_select  = transmit_status_control[TXS_SYNC_SELECT];
  wire clock_master = transmit_status_control[TXS_CLOCK_SOURCE_MASTER];
  wire cont_rx      = receive_status_control[RXS_CONTINUOUS_RECEIVE_ENABLE];
  wire single_rx    = receive_status_control[RXS_SINGLE_RECEIVE_ENABLE];
  wire slave_mode   = port_enable & sync_select & ~clock_master; // [R12]
  // only slave mode runs; other modes need the stopped system clock
  wire engine_run   = slave_mode; // [R01]
  wire receive_mode = cont_rx | single_rx;
  wire tx_enable    = transmit_status_control[TXS_TRANSMIT_ENABLE];

  // pin relocation selects which package pin carries clock and data
  wire sck_pin = pin_relocation_reg.clock_alternate ? clock_pin_b_in : clock_pin_a_in; // [R10]
  wire sdi_pin = pin_relocation_reg.data_alternate ? data_pin_b_in : data_pin_a_in;    // [R10]

  logic         sdo;
  logic         shifter_empty;
  logic         word_pulse;
  serial_word_s word_in;
  logic         tx_taken;

  slave_shift_engine #(
    .BITS (WORD_BITS)
  ) u_engine (
    .clk_in             (clk_in),
    .resetn_in          (resetn_in),
    .run_in             (engine_run),
    .receive_mode_in    (receive_mode),
    .nine_bit_in        (receive_mode ? receive_status_control[RXS_NINE_BIT]
                                      : transmit_status_control[TXS_NINE_BIT]),
    .clock_invert_in    (baud_control[BDC_CLOCK_INVERT]),
    .sck_in             (sck_pin),
    .sdi_in             (sdi_pin),
    .load_in            (transmit_buffer_full & tx_enable),
    .load_word_in       (transmit_buffer_reg),
    .sdo_out            (sdo),
    .shifter_empty_out  (shifter_empty),
    .word_pulse_out     (word_pulse),
    .word_out           (word_in),
    .tx_taken_pulse_out (tx_taken)
  );

  // AXI4-Lite write path: address and data accepted in either order
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [7:0]  w_data;
  wire         aw_take  = s_axi_awvalid & s_axi_awready;
  wire         w_take   = s_axi_wvalid & s_axi_wready;
  wire         wr_fire  = aw_held & w_held & ~s_axi_bvalid;
  wire [7:0]   wr_byte  = w_data;
  wire         wr_hit_txs  = wr_fire & (aw_addr == OFF_TRANSMIT_STATUS_CONTROL);
  wire         wr_hit_rxs  = wr_fire & (aw_addr == OFF_RECEIVE_STATUS_CONTROL);
  wire         wr_hit_bdc  = wr_fire & (aw_addr == OFF_BAUD_CONTROL);
  wire         wr_hit_txb  = wr_fire & (aw_addr == OFF_TRANSMIT_BUFFER);
  wire         wr_hit_pir  = wr_fire & (aw_addr == OFF_PERIPHERAL_IRQ_FLAGS);
  wire         wr_hit_pie  = wr_fire & (aw_addr == OFF_PERIPHERAL_IRQ_ENABLES);
  wire         wr_hit_icn  = wr_fire & (aw_addr == OFF_INTERRUPT_CONTROL);
  wire         wr_hit_pin  = wr_fire & (aw_addr == OFF_PIN_RELOCATION);
  wire         wr_hit_rxd  = wr_fire & (aw_addr == OFF_RECEIVE_DATA);
  wire         wr_hit_slp  = wr_fire & (aw_addr == OFF_SLEEP_CONTROL);
  wire         wr_known    = wr_hit_txs | wr_hit_rxs | wr_hit_bdc | wr_hit_txb | wr_hit_pir |
                             wr_hit_pie | wr_hit_icn | wr_hit_pin | wr_hit_rxd | wr_hit_slp;
  logic        w_strobe0;

  // write handshake registers
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 8'h00;
      w_strobe0     <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
    end else begin
      if (aw_take) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata[7:0];
        w_strobe0    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_known && !wr_hit_rxd) ? AXI_OKAY : AXI_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // a write lands only when byte lane zero is enabled
  wire wr_en = w_strobe0;

  // control register writes; unimplemented bits are masked away
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      transmit_status_control <= REG_RESET;
      receive_status_control  <= REG_RESET;
      baud_control            <= REG_RESET;
      peripheral_irq_enables  <= REG_RESET;
      interrupt_control       <= REG_RESET;
      pin_relocation_reg      <= '0;
    end else if (wr_en) begin
      if (wr_hit_txs) transmit_status_control <= wr_byte & TXS_WRITE_MASK; // [R11]
      if (wr_hit_rxs) receive_status_control  <= wr_byte & RXS_WRITE_MASK; // [R11]
      if (wr_hit_bdc) baud_control            <= wr_byte & BDC_WRITE_MASK; // [R11]
      if (wr_hit_pie) peripheral_irq_enables  <= wr_byte & PIE_WRITE_MASK; // [R11]
      if (wr_hit_icn) interrupt_control       <= wr_byte & ICN_WRITE_MASK; // [R11]
      if (wr_hit_pin) pin_relocation_reg      <= pin_select_s'(wr_byte[1:0]); // [R10]
    end
  end

  // AXI4-Lite read path and read decode
  wire        rd_take = s_axi_arvalid & s_axi_arready;
  wire [7:0]  ar_off  = s_axi_araddr[7:0];
  wire        rd_rxd  = rd_take & (ar_off == OFF_RECEIVE_DATA);
  wire [7:0]  txs_view = transmit_status_control | (8'(shifter_empty) << TXS_SHIFTER_EMPTY);
  wire [7:0]  rxs_view = receive_status_control | (8'(overrun) << RXS_OVERRUN)
                         | 8'(receive_data_reg.ninth); // [R14]
  wire [7:0]  bdc_view = baud_control | (8'(~engine_run | shifter_empty) << BDC_RECEIVE_IDLE);
  wire [7:0]  pir_view = (8'(receive_ready_flag) << PIR_RECEIVE_READY)
                         | (8'(transmit_space_flag) << PIR_TRANSMIT_SPACE);
  logic [7:0] rd_mux;
  logic       rd_known;
  always_comb begin
    rd_known = 1'b1;
    case (ar_off)
      OFF_TRANSMIT_STATUS_CONTROL: rd_mux = txs_view;
      OFF_RECEIVE_STATUS_CONTROL:  rd_mux = rxs_view;
      OFF_BAUD_CONTROL:            rd_mux = bdc_view;
      OFF_RECEIVE_DATA:            rd_mux = receive_data_reg.data;
      OFF_TRANSMIT_BUFFER:         rd_mux = 8'h00;
      OFF_PERIPHERAL_IRQ_FLAGS:    rd_mux = pir_view;
      OFF_PERIPHERAL_IRQ_ENABLES:  rd_mux = peripheral_irq_enables;
      OFF_INTERRUPT_CONTROL:       rd_mux = interrupt_control;
      OFF_PIN_RELOCATION:          rd_mux = {6'h00, pin_relocation_reg};
      OFF_SLEEP_CONTROL:           rd_mux = {7'h00, sleep_seen};
      default: begin
        rd_mux   = 8'h00;
        rd_known = 1'b0;
      end
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= AXI_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_mux}; // [R11]
      s_axi_rresp   <= rd_known ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // receive side: word capture, overrun, receive-ready; set wins over read clear
  wire rx_clear_overrun = ~cont_rx | ~port_enable; // [R13]
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      receive_data_reg   <= '0;
      receive_ready_flag <= 1'b0;
      overrun            <= 1'b0;
    end else begin
      if (word_pulse) begin
        if (receive_ready_flag && !rd_rxd) begin
          overrun <= 1'b1;
        end else begin
          receive_data_reg   <= word_in; // [R14]
          receive_ready_flag <= 1'b1; // [R04]
        end
      end else if (rd_rxd) begin
        receive_ready_flag <= 1'b0;
      end
      if (rx_clear_overrun) overrun <= 1'b0; // [R13]
    end
  end

  // transmit side: buffer empties into the shifter, transmit-space follows
  always_ff @(posedge clk_in) begin
    if (!resetn_in || !port_enable) begin
      transmit_buffer_reg  <= '0;
      transmit_buffer_full <= 1'b0;
      transmit_space_flag  <= 1'b1;
    end else if (wr_en && wr_hit_txb) begin
      transmit_buffer_reg  <= {transmit_status_control[TXS_TRANSMIT_NINTH_BIT], wr_byte};
      transmit_buffer_full <= 1'b1;
      transmit_space_flag  <= 1'b0; // [R09]
    end else if (tx_taken) begin
      transmit_buffer_full <= 1'b0;
      transmit_space_flag  <= 1'b1; // [R08]
    end
  end

  // interrupt, wake and vector; flags are already in the system domain
  wire rx_req   = receive_ready_flag & peripheral_irq_enables[PIR_RECEIVE_READY];
  wire tx_req   = transmit_space_flag & peripheral_irq_enables[PIR_TRANSMIT_SPACE];
  wire periph   = (rx_req | tx_req) & interrupt_control[ICN_PERIPHERAL_IRQ_ENABLE];
  wire glob     = interrupt_control[ICN_GLOBAL_IRQ_ENABLE];
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wake_out        <= 1'b0;
      vector_call_out <= 1'b0;
      vector_addr_out <= 12'h000;
      irq_out         <= 1'b0;
      sleep_seen      <= 1'b0;
    end else begin
      wake_out        <= sleeping_in & periph; // [R04] [R15]
      vector_call_out <= sleeping_in & periph & glob; // [R05]
      vector_addr_out <= (periph & glob) ? IRQ_VECTOR : 12'h000; // [R05]
      irq_out         <= periph & glob;
      sleep_seen      <= sleeping_in;
    end
  end

  // data pin drive in slave transmit, at the selected location
  wire drive = slave_mode & ~receive_mode & tx_enable; // [R07]
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      data_pin_a_out    <= 1'b0;
      data_pin_a_oe_out <= 1'b0;
      data_pin_b_out    <= 1'b0;
      data_pin_b_oe_out <= 1'b0;
    end else begin
      data_pin_a_out    <= sdo;
      data_pin_b_out    <= sdo;
      data_pin_a_oe_out <= drive & ~pin_relocation_reg.data_alternate; // [R10]
      data_pin_b_oe_out <= drive & pin_relocation_reg.data_alternate; // [R10]
    end
  end

  // checks
  sequence s_write_txb;
    wr_en && wr_hit_txb && !tx_taken;
  endsequence
  tx_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_write_txb and port_enable) |=> !transmit_space_flag) // [R09]
    else $error("transmit space not cleared by write");
  tx_set_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    port_enable && tx_taken && !(wr_en && wr_hit_txb) |=> transmit_space_flag) // [R08]
    else $error("transmit space not set on load");
  rx_set_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    word_pulse && !receive_ready_flag |=> receive_ready_flag) // [R04]
    else $error("receive ready not set");
  ovr_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    rx_clear_overrun |=> !overrun) // [R13]
    else $error("overrun not cleared");
  wake_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sleeping_in && periph |=> wake_out) // [R04]
    else $error("no wake on enabled flag");
  vector_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    vector_call_out |-> vector_addr_out == IRQ_VECTOR) // [R05]
    else $error("wrong vector");
  run_mode_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !slave_mode |=> !word_pulse && !tx_taken) // [R12]
    else $error("engine running outside slave mode");
  read_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) // [R11]
    else $error("upper read bits not zero");
  pin_sel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(data_pin_a_oe_out && data_pin_b_oe_out)) // [R10]
    else $error("both data pins driven");
endmodule

//--- serial_master_model.sv
// partner model: external serial master that drives the shift clock
`timescale 1ns/1ps
module serial_master_model (
  output logic      sck_out,
  output logic      sdo_out,
  input  wire logic sdi_in
);
  logic [7:0] got;
  // clock idles low and stands still between words
  initial begin
    sck_out = 1'b0;
    sdo_out = 1'b0;
  end
  // one word, lsb first; data set before rise, port data sampled at rise
  task automatic xfer(input logic [7:0] tx);
    #3; // keep pin changes clear of the port's sampling edge
    for (int i = 0; i < 8; i++) begin
      sdo_out = tx[i];
      #80 sck_out = 1'b1;
      got[i] = sdi_in;
      #80 sck_out = 1'b0;
    end
    sdo_out = ~tx[7]; // driven to the inverse of the last bit: no stale level left on the line
  endtask
endmodule

//--- sync_slave_serial_sleep_bench.sv
// bench: register bus, sleep receive and sleep transmit
`timescale 1ns/1ps
module sync_slave_serial_sleep_bench
  import sync_slave_pkg::*;
;
  logic        clk_in, resetn_in, sleeping_in, clock_pin_a_in, clock_pin_b_in, mdo;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bready;
  logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        data_pin_a_in, data_pin_b_in, data_pin_a_out, data_pin_a_oe_out, irq_out;
  logic        data_pin_b_out, data_pin_b_oe_out, wake_out, vector_call_out;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [11:0] vector_addr_out;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          error_cnt, n_checks;
  sync_slave_serial_sleep uut (.*);
  serial_master_model mst (.sck_out(clock_pin_a_in), .sdo_out(mdo), .sdi_in(data_pin_a_in));
  // data wire: the port owns it only while its enable is up
  assign data_pin_a_in = data_pin_a_oe_out ? data_pin_a_out : mdo;
  // 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // write: each channel released at its own take
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bit pa, pw;
    @(posedge clk_in);
    {pa, pw} = 2'b11;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (pa || pw) begin
      @(posedge clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
    end
    do @(posedge clk_in); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge clk_in); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_in); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_regs;
    rd(OFF_RECEIVE_STATUS_CONTROL);
    chk(d, 32'h0);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h7F);
    chk({30'h0, r}, {30'h0, AXI_OKAY});
    wr(OFF_RECEIVE_DATA, 8'h55);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    rd(OFF_RECEIVE_STATUS_CONTROL);
    chk(d, 32'h70);
    rd(8'h40);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    $display("done regs");
  endtask
  task automatic t_rx;
    wr(OFF_TRANSMIT_STATUS_CONTROL, 8'h10);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h90);
    wr(OFF_PERIPHERAL_IRQ_ENABLES, 8'h20);
    wr(OFF_INTERRUPT_CONTROL, 8'hC0);
    sleeping_in <= 1'b1;
    mst.xfer(8'hA5);
    repeat (8) @(posedge clk_in);
    chk({30'h0, wake_out, vector_call_out}, 32'h3);
    chk({20'h0, vector_addr_out}, 32'h4);
    sleeping_in <= 1'b0;
    rd(OFF_RECEIVE_DATA);
    chk(d, 32'hA5);
    rd(OFF_PERIPHERAL_IRQ_FLAGS);
    chk(d & 32'h20, 32'h0);
    $display("done receive");
  endtask
  task automatic t_tx;
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h80);
    wr(OFF_TRANSMIT_STATUS_CONTROL, 8'h30);
    wr(OFF_PERIPHERAL_IRQ_ENABLES, 8'h10);
    wr(OFF_TRANSMIT_BUFFER, 8'h3C);
    wr(OFF_TRANSMIT_BUFFER, 8'h5A);
    rd(OFF_PERIPHERAL_IRQ_FLAGS);
    chk(d, 32'h0);
    sleeping_in <= 1'b1;
    mst.xfer(8'h00);
    chk({24'h0, mst.got}, 32'h3C);
    repeat (8) @(posedge clk_in);
    chk({30'h0, wake_out, irq_out}, 32'h3);
    rd(OFF_PERIPHERAL_IRQ_FLAGS);
    chk(d, 32'h10);
    wr(OFF_TRANSMIT_BUFFER, 8'h11);
    rd(OFF_PERIPHERAL_IRQ_FLAGS);
    chk(d, 32'h0);
    wr(OFF_PIN_RELOCATION, 8'h02);
    repeat (2) @(posedge clk_in);
    chk({29'h0, data_pin_a_oe_out, data_pin_b_oe_out, data_pin_b_out}, 32'h2);
    $display("done transmit");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // main sequence: inputs quiet at time zero, reset held four cycles
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {sleeping_in, clock_pin_b_in, data_pin_b_in, resetn_in} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_regs();
    t_rx();
    t_tx();
    final_report();
  end
  // watchdog: fires at 100 us, the whole run needs well under 10 us
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule
